//--- logic/rcm_pkg.sv
package rcm_pkg;
   // Register offsets (byte addresses).
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_COND = 8'h04;
   localparam logic [7:0] ADDR_EFFECT = 8'h08;
   localparam logic [7:0] ADDR_DIAG = 8'h0C;
   localparam logic [7:0] ADDR_WAKE = 8'h10;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h1C;
   localparam logic [7:0] ADDR_CNT = 8'h20;
   // Condition bit positions.
   localparam int C_IPOR = 0;
   localparam int C_EPOR = 1;
   localparam int C_UV5 = 2;
   localparam int C_OV5 = 3;
   localparam int C_UVT = 4;
   localparam int C_OVT = 5;
   localparam int C_OVB = 6;
   localparam int NCOND = 7;
   // Control bit positions.
   localparam int K_BUS_EN = 0;
   localparam int K_WAKE_A = 1;
   localparam int K_WAKE_B = 2;
   localparam int K_AFTERRUN = 3;
   localparam int K_AUX = 4;
   localparam int K_DELAY_KEEP = 5;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // Release delay before configuration is accepted.
   localparam int REL_DELAY_NS = 1000;
   localparam int CLK_PERIOD_NS = 4;
   localparam int REL_CYCLES = (REL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DOFF_DELAY_NS = 4000;
   localparam int DOFF_CYCLES = DOFF_DELAY_NS / CLK_PERIOD_NS;
   // Bus transceiver modes.
   typedef enum logic [1:0] {RCM_BUS_OFF, RCM_BUS_RXONLY, RCM_BUS_CFG} rcm_bus_mode_t;
endpackage : rcm_pkg

//--- logic/rcm_matrix.sv
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
// Notes on behaviour
// - Power stages off except tracker conditions.
// - Serial and SPI off for resets, 5V faults.
// - Delayed outputs off, or delayed off on 5V.
// - Bus off, receive-only, else follows enables.
// - Release delay before bus configuration accepted.
// - Reset pins low for resets, 5V faults.
// - Internal reset pulldown only with supply.
// - Watchdog sequence reset, restarts after release.
// - Clear watchdog counters, flags, configuration.
// - General bits reset; wake flags on undervoltage.
// - General reset covers only the interrupt enables.
// - Delayed switch-off keeps only the delay-keep control bit.
// - Combined wake is OR of three flags.
module rcm_matrix (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic [6:0] COND_IN,
   input wire logic SUPPLY_OK,
   input wire logic RESET_PIN_IN,
   input wire logic WAKE_INT_EV,
   input wire logic WAKE_BUS_EV,
   input wire logic WAKE_EOT_EV,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   output logic STAGES_EN,
   output logic SERIAL_EN,
   output logic DOFF_A_EN,
   output logic DOFF_B_EN,
   output logic [1:0] BUS_MODE,
   output logic RESET_PIN_OE,
   output logic RESET_PIN_OUT,
   output logic PERIPH_RESET_PIN_OE,
   output logic PERIPH_RESET_PIN_OUT,
   output logic WD_RESTART,
   output logic WAKE_ANY,
   output logic IRQ
);
   typedef struct packed {
      logic [6:0] c1;
      logic [6:0] c2;
      logic [6:0] prev;
      logic rp1;
      logic rp2;
      logic rp_prev;
      logic sup1;
      logic sup2;
      logic [7:0] ctrl;
      logic [6:0] diag;
      logic [2:0] wake;
      logic [6:0] irq_stat;
      logic [6:0] irq_en;
      logic [15:0] rel_cnt;
      logic cfg_ok;
      logic [15:0] doff_cnt;
      logic doff_on;
      logic [7:0] wd_cnt;
      logic wd_hold;
      logic wd_restart;
      logic stages;
      logic [1:0] bus_mode;
      logic serial;
      logic pin_low;
      logic ph_act;
      logic ph_wr;
      logic [7:0] ph_addr;
      logic [31:0] rdata;
   } rcm_state_t;

   rcm_state_t s_q;
   rcm_state_t s_d;
   logic [6:0] cnd;
   logic rst_grp;
   logic stage_off;
   logic por_any;
   logic gen_clr;
   logic doff_kill;
   logic doff_run;
   logic bus_off;
   logic bus_rx;
   logic pd_ok;
   logic [7:0] ctrl_kept;
   logic [6:0] cnd_rise;
   logic [6:0] diag_set;
   logic [31:0] rd_word;

   assign cnd = s_q.c2;
   assign rst_grp = cnd[rcm_pkg::C_IPOR] | cnd[rcm_pkg::C_EPOR] | cnd[rcm_pkg::C_UV5]
      | cnd[rcm_pkg::C_OV5];
   assign stage_off = rst_grp | cnd[rcm_pkg::C_OVB];
   assign por_any = cnd[rcm_pkg::C_IPOR] | cnd[rcm_pkg::C_EPOR];
   assign gen_clr = por_any | cnd[rcm_pkg::C_UV5];
   assign doff_kill = por_any | cnd[rcm_pkg::C_OVB];
   assign doff_run = cnd[rcm_pkg::C_UV5] | cnd[rcm_pkg::C_OV5];
   assign bus_off = cnd[rcm_pkg::C_IPOR] | cnd[rcm_pkg::C_OV5];
   assign bus_rx = cnd[rcm_pkg::C_EPOR] | cnd[rcm_pkg::C_UV5];
   assign pd_ok = s_q.sup2 | ~cnd[rcm_pkg::C_IPOR];
   assign ctrl_kept = s_q.ctrl & (8'h01 << rcm_pkg::K_DELAY_KEEP);

   for (genvar i = 0; i < rcm_pkg::NCOND; i++) begin : g_cond
      assign cnd_rise[i] = cnd[i] & ~s_q.prev[i];
      assign diag_set[i] = cnd[i] & (i != rcm_pkg::C_OV5) & (i != rcm_pkg::C_IPOR)
         & (i != rcm_pkg::C_EPOR);
   end : g_cond

   always_comb begin
      rd_word = 32'h00000000;
      unique case (HADDR[7:0])
         rcm_pkg::ADDR_CTRL: begin
            rd_word = {24'h000000, s_q.ctrl};
         end
         rcm_pkg::ADDR_COND: begin
            rd_word = {25'h0000000, cnd};
         end
         rcm_pkg::ADDR_EFFECT: begin
            rd_word = {24'h000000, s_q.bus_mode, s_q.pin_low,
               s_q.doff_on, s_q.serial, s_q.stages, s_q.cfg_ok, s_q.wd_hold};
         end
         rcm_pkg::ADDR_DIAG: begin
            rd_word = {25'h0000000, s_q.diag};
         end
         rcm_pkg::ADDR_WAKE: begin
            rd_word = {29'h00000000, s_q.wake};
         end
         rcm_pkg::ADDR_IRQ_STAT: begin
            rd_word = {25'h0000000, s_q.irq_stat};
         end
         rcm_pkg::ADDR_IRQ_EN: begin
            rd_word = {25'h0000000, s_q.irq_en};
         end
         rcm_pkg::ADDR_CNT: begin
            rd_word = {24'h000000, s_q.wd_cnt};
         end
         default: begin
            rd_word = 32'h00000000;
         end
      endcase
   end

   always_comb begin
      s_d = s_q;
      s_d.c1 = COND_IN;
      s_d.c2 = s_q.c1;
      s_d.prev = cnd;
      s_d.rp1 = RESET_PIN_IN;
      s_d.rp2 = s_q.rp1;
      s_d.rp_prev = s_q.rp2;
      s_d.sup1 = SUPPLY_OK;
      s_d.sup2 = s_q.sup1;
      s_d.wd_restart = 1'b0;
      s_d.stages = ~stage_off;
      s_d.serial = ~rst_grp;
      if (doff_kill) begin
         s_d.doff_on = 1'b0;
         s_d.doff_cnt = '0;
      end else if (doff_run) begin
         if (s_q.doff_cnt == 16'(rcm_pkg::DOFF_CYCLES)) begin
            s_d.doff_on = 1'b0;
         end else begin
            s_d.doff_cnt = s_q.doff_cnt + 16'h0001;
         end
      end else begin
         s_d.doff_on = 1'b1;
         s_d.doff_cnt = '0;
      end
      if (rst_grp | ~s_q.rp2) begin
         s_d.cfg_ok = 1'b0;
         s_d.rel_cnt = '0;
      end else if (!s_q.cfg_ok) begin
         if (s_q.rel_cnt == 16'(rcm_pkg::REL_CYCLES)) begin
            s_d.cfg_ok = 1'b1;
         end else begin
            s_d.rel_cnt = s_q.rel_cnt + 16'h0001;
         end
      end
      if (bus_off) begin
         s_d.bus_mode = rcm_pkg::RCM_BUS_OFF;
      end else if (bus_rx | ~s_q.cfg_ok) begin
         s_d.bus_mode = rcm_pkg::RCM_BUS_RXONLY;
      end else if (s_q.ctrl[rcm_pkg::K_BUS_EN] | s_q.ctrl[rcm_pkg::K_WAKE_A]
            | s_q.ctrl[rcm_pkg::K_WAKE_B]) begin
         s_d.bus_mode = rcm_pkg::RCM_BUS_CFG;
      end else begin
         s_d.bus_mode = rcm_pkg::RCM_BUS_OFF;
      end
      s_d.pin_low = rst_grp;
      if (rst_grp) begin
         s_d.wd_hold = 1'b1;
         s_d.wd_cnt = '0;
      end else begin
         s_d.wd_hold = 1'b0;
         s_d.wd_restart = s_q.wd_hold;
         s_d.wd_cnt = s_q.wd_cnt + 8'h01;
      end
      s_d.irq_stat = s_q.irq_stat;
      // Bus data phase.
      s_d.ph_act = 1'b0;
      if (s_q.ph_act && s_q.ph_wr) begin
         unique case (s_q.ph_addr)
            rcm_pkg::ADDR_CTRL: begin
               s_d.ctrl = HWDATA[7:0];
            end
            rcm_pkg::ADDR_DIAG: begin
               s_d.diag = s_q.diag & ~HWDATA[6:0];
            end
            rcm_pkg::ADDR_WAKE: begin
               s_d.wake = s_q.wake & ~HWDATA[2:0];
            end
            rcm_pkg::ADDR_IRQ_EN: begin
               s_d.irq_en = HWDATA[6:0];
            end
            rcm_pkg::ADDR_IRQ_CLR: begin
               s_d.irq_stat = s_q.irq_stat & ~HWDATA[6:0];
            end
            default: begin
            end
         endcase
      end
      s_d.wake = s_d.wake | {WAKE_EOT_EV, WAKE_BUS_EV, WAKE_INT_EV};
      s_d.diag = s_d.diag | diag_set;
      // Condition rising edges raise sticky status; the set wins over a clear.
      s_d.irq_stat = s_d.irq_stat | cnd_rise;
      if (cnd[rcm_pkg::C_UV5]) begin
         s_d.wake = '0;
      end
      if (gen_clr) begin
         s_d.irq_en = '0;
      end
      if (por_any) begin
         s_d.diag = '0;
      end
      if (rst_grp) begin
         if (s_q.doff_on & s_q.ctrl[rcm_pkg::K_DELAY_KEEP]) begin
            s_d.ctrl = ctrl_kept;
         end else begin
            s_d.ctrl = rcm_pkg::CTRL_RESET;
         end
      end
      if (HSEL && HREADY && HTRANS[1]) begin
         s_d.ph_act = 1'b1;
         s_d.ph_wr = HWRITE;
         s_d.ph_addr = HADDR[7:0];
         s_d.rdata = rd_word;
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign HRDATA = s_q.rdata;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign STAGES_EN = s_q.stages;
   assign SERIAL_EN = s_q.serial;
   assign DOFF_A_EN = s_q.doff_on;
   assign DOFF_B_EN = s_q.doff_on;
   assign BUS_MODE = s_q.bus_mode;
   assign RESET_PIN_OE = s_q.pin_low & pd_ok;
   assign RESET_PIN_OUT = 1'b0;
   assign PERIPH_RESET_PIN_OE = RESET_PIN_OE;
   assign PERIPH_RESET_PIN_OUT = 1'b0;
   assign WD_RESTART = s_q.wd_restart;
   assign WAKE_ANY = |s_q.wake;
   assign IRQ = |(s_q.irq_stat & s_q.irq_en);
endmodule : rcm_matrix

//--- bench/rcm_checker.sv
`timescale 1ns/1ps
module rcm_checker (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic [6:0] COND_IN,
   input wire logic SUPPLY_OK,
   input wire logic WAKE_BUS_EV,
   input wire logic STAGES_EN,
   input wire logic SERIAL_EN,
   input wire logic DOFF_A_EN,
   input wire logic DOFF_B_EN,
   input wire logic [1:0] BUS_MODE,
   input wire logic RESET_PIN_OE,
   input wire logic PERIPH_RESET_PIN_OE,
   input wire logic WD_RESTART,
   input wire logic WAKE_ANY
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SRST);
   property p_pins; (|COND_IN[3:1]) [*4] |-> RESET_PIN_OE && PERIPH_RESET_PIN_OE; endproperty
   a_pins: assert property (p_pins) else $error("pins");
   property p_pdn; (COND_IN[0] && SUPPLY_OK) [*4] |-> RESET_PIN_OE && PERIPH_RESET_PIN_OE; endproperty
   a_pdn: assert property (p_pdn) else $error("pulldown");
   property p_stg; (|(COND_IN & 7'h4F)) [*4] |-> !STAGES_EN; endproperty
   a_stg: assert property (p_stg) else $error("stages");
   property p_ser; (|COND_IN[3:0]) [*4] |-> !SERIAL_EN; endproperty
   a_ser: assert property (p_ser) else $error("serial");
   property p_doff; (|(COND_IN & 7'h43)) [*4] |-> !(DOFF_A_EN || DOFF_B_EN); endproperty
   a_doff: assert property (p_doff) else $error("doff");
   property p_bus; (COND_IN[0] || COND_IN[3]) [*4] |-> BUS_MODE == 2'h0; endproperty
   a_bus: assert property (p_bus) else $error("bus");
   property p_wake; $rose(WAKE_BUS_EV) |-> ##[1:3] WAKE_ANY; endproperty
   a_wake: assert property (p_wake) else $error("wake");
   property p_wd; $fell(|COND_IN[3:0]) |-> ##[2:6] WD_RESTART; endproperty
   a_wd: assert property (p_wd) else $error("restart");
endmodule : rcm_checker
bind rcm_matrix rcm_checker CHK (.*);

//--- bench/rcm_host.sv
`timescale 1ns/1ps
module rcm_host (
   input wire logic rst_oe,
   input wire logic mon_oe,
   output logic rst_lvl,
   output logic mon_lvl
);
   assign rst_lvl = !rst_oe;
   assign mon_lvl = !mon_oe;
endmodule : rcm_host

//--- bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'h0;
   logic srst = 1'h1;
   logic sup = 1'h1;
   logic we = 1'h0;
   logic wk = 1'h0;
   logic [1:0] trans = 2'h0;
   logic [6:0] cond = 7'h00;
   logic [31:0] addr = 32'h0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata, rd;
   logic rdy, stg, ser, da, db, oe, poe, wdr, wany, irq, rl, ml;
   logic resp, ro, po;
   logic [1:0] bm;
   logic [12:0] r;
   int miscompares = 0;
   int comparisons = 0;
   int cyc = 0;
   logic [12:0] rows [8] = '{13'h007C, 13'h00BD, 13'h0139, 13'h0238, 13'h0403, 13'h0803,
      13'h1017, 13'h1417};
   always #2 clk = !clk;
   rcm_matrix DUT (.CLK(clk), .SRST(srst), .COND_IN(cond), .SUPPLY_OK(sup),
      .RESET_PIN_IN(rl), .WAKE_INT_EV(1'h0), .WAKE_BUS_EV(wk), .WAKE_EOT_EV(1'h0),
      .HSEL(1'h1), .HADDR(addr), .HTRANS(trans), .HWRITE(we), .HSIZE(3'h2),
      .HWDATA(wdata), .HREADY(rdy), .HRDATA(rdata), .HREADYOUT(rdy), .HRESP(resp),
      .STAGES_EN(stg), .SERIAL_EN(ser), .DOFF_A_EN(da), .DOFF_B_EN(db), .BUS_MODE(bm),
      .RESET_PIN_OE(oe), .RESET_PIN_OUT(ro), .PERIPH_RESET_PIN_OE(poe),
      .PERIPH_RESET_PIN_OUT(po), .WD_RESTART(wdr), .WAKE_ANY(wany), .IRQ(irq));
   rcm_host HOST (.rst_oe(oe), .mon_oe(poe), .rst_lvl(rl), .mon_lvl(ml));
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask : wt
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      addr <= {24'h0, a};
      we <= w;
      trans <= 2'h2;
      @(posedge clk);
      while (rdy !== 1'h1) @(posedge clk);
      trans <= 2'h0;
      wdata <= d;
      @(posedge clk);
      while (rdy !== 1'h1) @(posedge clk);
      rd = rdata;
   endtask : bus
   task automatic stop_test;
      if (miscompares == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         miscompares++;
         stop_test();
      end
   end
   initial begin
      wt(6);
      srst <= 1'h0;
      wt(2);
      bus(1'h0, rcm_pkg::ADDR_CTRL, 32'h0);
      chk("ctrl", 32'(rcm_pkg::CTRL_RESET), rd);
      foreach (rows[i]) begin
         r = rows[i];
         cond <= r[12:6];
         wt(5);
         chk("pins", 32'(!r[5]), 32'(rl & ml));
         chk("serial", 32'(!r[3]), 32'(ser));
         if (r[4]) chk("stages", 32'h0, 32'(stg));
         if (r[2]) chk("doff", 32'h0, 32'({da, db}));
         if (r[1:0] != 2'h3) chk("bus", 32'(r[1:0]), 32'(bm));
         cond <= 7'h00;
         wt(8);
      end
      bus(1'h1, rcm_pkg::ADDR_IRQ_CLR, 32'h7F);
      bus(1'h1, rcm_pkg::ADDR_IRQ_EN, 32'h10);
      cond <= 7'h10;
      wt(5);
      chk("irq", 32'h1, 32'(irq));
      bus(1'h1, rcm_pkg::ADDR_IRQ_CLR, 32'h10);
      wt(2);
      chk("irq_clr", 32'h0, 32'(irq));
      cond <= 7'h30;
      wt(5);
      bus(1'h0, rcm_pkg::ADDR_IRQ_STAT, 32'h0);
      chk("irq_stat", 32'h20, rd);
      chk("irq_mask", 32'h0, 32'(irq));
      chk("hresp", 32'h0, 32'(resp));
      bus(1'h1, rcm_pkg::ADDR_DIAG, 32'h7F);
      bus(1'h0, rcm_pkg::ADDR_DIAG, 32'h0);
      chk("diag_set_wins", 32'h30, rd);
      bus(1'h0, 8'h40, 32'h0);
      chk("unmapped", 32'h0, rd);
      bus(1'h1, rcm_pkg::ADDR_CTRL, 32'h21);
      wk <= 1'h1;
      cond <= 7'h08;
      wt(1);
      wk <= 1'h0;
      wt(6);
      chk("wake_ov", 32'h1, 32'(wany));
      cond <= 7'h04;
      wt(6);
      chk("wake_uv", 32'h0, 32'(wany));
      bus(1'h0, rcm_pkg::ADDR_CTRL, 32'h0);
      chk("ctrl_keep", 32'h20, rd);
      wt(rcm_pkg::DOFF_CYCLES + 10);
      chk("doff_late", 32'h0, 32'({da, db}));
      bus(1'h1, rcm_pkg::ADDR_CTRL, 32'h1F);
      cond <= 7'h02;
      wt(6);
      bus(1'h0, rcm_pkg::ADDR_CTRL, 32'h0);
      chk("ctrl_clr", 32'h0, rd);
      cond <= 7'h00;
      wt(6);
      bus(1'h1, rcm_pkg::ADDR_CTRL, 32'h1);
      wt(rcm_pkg::REL_CYCLES - 60);
      chk("cfg_early", 32'h0, 32'(bm == 2'h2));
      wt(80);
      chk("cfg_late", 32'h2, 32'(bm));
      sup <= 1'h0;
      cond <= 7'h01;
      wt(5);
      chk("pulldown", 32'h0, 32'({oe, poe}));
      chk("pin_out", 32'h0, 32'({ro, po}));
      stop_test();
   end
endmodule : tb_top
